/* test/esc_classifier_properties.sv */
// Purpose: Port checks for the error state classifier.
// Assumes: Bound into every esc_classifier.
// Notes:   Take checks skip cycles frozen by ce_in.
`timescale 1ns/1ps
`default_nettype none
module esc_classifier_properties #(
	parameter int SLOTS = 4
) (
	// Inputs
	input wire logic              clk_in,
	input wire logic              reset_n_in,
	input wire logic              ce_in,
	input wire esc_pkg::esc_cfg_t cfg_in,
	input wire logic              take_in,
	// Outputs
	input wire logic              exc_valid_out,
	input wire esc_pkg::esc_syn_t exc_syn_out,
	input wire logic [SLOTS-1:0]  exc_mask_out,
	input wire logic [SLOTS-1:0]  pending_out,
	input wire logic              lost_out
);
	import esc_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	a_take_pulse:
	assert property (ce_in && take_in && |pending_out |=> exc_valid_out)
		else $error("take missed");
	a_idle_take:
	assert property (ce_in && !(take_in && |pending_out) |=> !exc_valid_out)
		else $error("spurious take");
	a_mask_pend:
	assert property (exc_valid_out && $past(ce_in) |-> |exc_mask_out &&
		(exc_mask_out & ~$past(pending_out)) == '0) else $error("bad mask");
	a_mask_clear:
	assert property (exc_valid_out && $past(ce_in) |->
		(pending_out & exc_mask_out) == '0) else $error("slot not freed");
	a_rest_stay:
	assert property (exc_valid_out && $past(ce_in) |->
		($past(pending_out) & ~exc_mask_out & ~pending_out) == '0)
		else $error("slot lost");
	a_lowest_sel:
	assert property (exc_valid_out && $past(ce_in) |->
		|(exc_mask_out & $past(pending_out) & -$past(pending_out)))
		else $error("wrong slot");
	a_one_slot:
	assert property (exc_valid_out && !cfg_in.merge_en |->
		$onehot(exc_mask_out)) else $error("merged while off");
	a_narrow_four:
	assert property (exc_valid_out && !exc_syn_out.to_64 |-> exc_syn_out.state
		inside {ESC_ST_UNCONT, ESC_ST_UNREC, ESC_ST_RECOV, ESC_ST_RESTART})
		else $error("narrow state");
	a_impl_zero:
	assert property (exc_valid_out && exc_syn_out.state != ESC_ST_IMPL |->
		exc_syn_out.impl_info == '0) else $error("stray info");
	c_merge: cover property (exc_valid_out && !$onehot(exc_mask_out));
	c_lost: cover property (lost_out);
	c_impl: cover property (exc_valid_out && exc_syn_out.state == ESC_ST_IMPL);
endmodule
bind esc_classifier esc_classifier_properties #(.SLOTS(SLOTS)) chk_inst (
	.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
	.cfg_in(cfg_in), .take_in(take_in), .exc_valid_out(exc_valid_out),
	.exc_syn_out(exc_syn_out), .exc_mask_out(exc_mask_out),
	.pending_out(pending_out), .lost_out(lost_out));
`default_nettype wire

/* test/esc_err_source.sv */
// Purpose: Far-side source of in-band error conditions.
// Assumes: One request per cycle at most.
// Notes:   Idle data toggles so stale values never pass.
`timescale 1ns/1ps
`default_nettype none
module esc_err_source (
	// Request
	input  wire logic              clk_in,
	input  wire logic              send_in,
	input  wire esc_pkg::esc_err_t data_in,
	// Error response
	output logic                   valid_out,
	output esc_pkg::esc_err_t      err_out
);
	// One process owns both outputs, starting from idle
	initial begin
		valid_out = 1'b0;
		err_out = '0;
		forever begin
			@(posedge clk_in);
			valid_out <= send_in;
			// Severity bits arrive only sometimes
			err_out <= send_in ? data_in : ~err_out;
		end
	end
endmodule
`default_nettype wire

/* test/test_esc_classifier.sv */
// Purpose: Random self-checking bench for the classifier.
// Assumes: Configuration changes only under reset.
// Notes:   Model mirrors slots from port activity.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) checks++; if ((a) !== (e)) begin \
	$display("mismatch %s exp %h got %h", n, e, a); bad_count++; end
module test_esc_classifier;
	import esc_pkg::*;
	localparam int SL = 4;
	logic                  clk_in, reset_n_in, ce_in, take_in, send;
	logic                  err_valid_in, exc_valid_out, lost_out;
	logic                  armed, ev, el, imp, unc, mt[SL];
	logic [SL-1:0]         exc_mask_out, pending_out, mp, em, fr;
	logic [ESC_IMPL_W-1:0] mi[SL];
	logic [31:0]           seed, r, r2;
	esc_cfg_t              cfg_in;
	esc_err_t              data, err_in;
	esc_syn_t              exc_syn_out, es;
	esc_state_t            ms[SL];
	int                    bad_count, checks, k;
	esc_err_source esc_err_source_inst (.clk_in(clk_in), .send_in(send),
		.data_in(data), .valid_out(err_valid_in), .err_out(err_in));
	esc_classifier #(.SLOTS(SL)) esc_classifier_inst (.clk_in(clk_in),
		.reset_n_in(reset_n_in), .ce_in(ce_in), .cfg_in(cfg_in),
		.err_valid_in(err_valid_in), .err_in(err_in), .take_in(take_in),
		.exc_valid_out(exc_valid_out), .exc_syn_out(exc_syn_out),
		.exc_mask_out(exc_mask_out), .pending_out(pending_out),
		.lost_out(lost_out));
	always #5 clk_in = ~clk_in;
	function automatic esc_state_t cls(input esc_err_t e, input esc_cfg_t c);
		logic w;
		w = e.async_exc & e.to_64;
		if (w & c.elect_uncat)
			return ESC_ST_UNCAT;
		if (w & c.elect_impl)
			return ESC_ST_IMPL;
		if (e.silent | (c.use_severity & e.sev_valid & e.sev_uncont) |
			(!e.resumable & !e.synced))
			return ESC_ST_UNCONT;
		if (!e.resumable)
			return ESC_ST_UNREC;
		if (e.needs_repair)
			return ESC_ST_RECOV;
		if (e.corrected & e.to_64)
			return ESC_ST_CORR;
		return ESC_ST_RESTART;
	endfunction
	task automatic end_sim;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk_in) begin
		if (armed) begin
			`CHK("valid", ev, exc_valid_out)
			`CHK("mask", em, exc_mask_out)
			`CHK("syndrome", es, exc_syn_out)
			`CHK("pending", mp, pending_out)
			`CHK("lost", el, lost_out)
		end
		if (!reset_n_in) begin
			armed = 1'b1;
			mp = '0;
			em = '0;
			es = '0;
			ev = 1'b0;
			el = 1'b0;
		end else if (ce_in) begin
			fr = mp;
			ev = take_in && mp != '0;
			em = '0;
			if (ev) begin
				for (int i = SL - 1; i >= 0; i--)
					if (mp[i])
						k = i;
				es = '0;
				es.to_64 = mt[k];
				es.state = ESC_ST_CORR;
				imp = 1'b0;
				unc = 1'b0;
				for (int i = 0; i < SL; i++)
					if (mp[i] && (i == k || (cfg_in.merge_en && mt[i] == mt[k]))) begin
						em[i] = 1'b1;
						// Info of every folded slot, kept only for IMPL
						es.impl_info |= mi[i];
						if (ms[i] == ESC_ST_IMPL) begin
							imp = 1'b1;
						end else if (ms[i] == ESC_ST_UNCAT)
							unc = 1'b1;
						// Graded codes fall as severity rises
						else if (ms[i] < es.state)
							es.state = ms[i];
					end
				if (imp)
					es.state = ESC_ST_IMPL;
				else if (unc)
					es.state = ESC_ST_UNCAT;
				if (!imp)
					es.impl_info = '0;
			end
			mp &= ~em;
			el = err_valid_in && fr == '1;
			if (err_valid_in && !el) begin
				for (int i = SL - 1; i >= 0; i--)
					if (!fr[i])
						k = i;
				mp[k] = 1'b1;
				ms[k] = cls(err_in, cfg_in);
				mt[k] = err_in.to_64;
				mi[k] = err_in.impl_info;
			end
		end
	end
	initial begin
		seed = 32'he428;
		clk_in = 1'b0;
		reset_n_in = 1'b0;
		ce_in = 1'b1;
		take_in = 1'b0;
		send = 1'b0;
		data = '0;
		cfg_in = '0;
		armed = 1'b0;
		bad_count = 0;
		checks = 0;
		for (int ph = 0; ph < 32; ph++) begin
			@(posedge clk_in);
			reset_n_in <= 1'b0;
			ce_in <= 1'b1;
			cfg_in <= esc_cfg_t'(ph[3:0]);
			repeat (2) @(posedge clk_in);
			reset_n_in <= 1'b1;
			// Corner: overflow every slot, then take while still full
			take_in <= 1'b0;
			send <= 1'b1;
			repeat (SL + 2) @(posedge clk_in);
			take_in <= 1'b1;
			@(posedge clk_in);
			take_in <= 1'b0;
			send <= 1'b0;
			// Rare takes fill every slot; frequent takes run back to back
			repeat (100) begin
				@(posedge clk_in);
				r = $random(seed);
				r2 = $random(seed);
				ce_in <= r[2:0] != 3'h0;
				take_in <= r[5:3] < {ph[4], 2'h1};
				send <= r[6] | r[7];
				data <= r2[$bits(esc_err_t)-1:0];
			end
		end
		end_sim;
	end
	initial begin
		repeat (5000) @(posedge clk_in);
		bad_count++;
		end_sim;
	end
endmodule
`default_nettype wire

/* verilog/esc_classifier.sv */
// Purpose: Record, hold and take pending system error interrupt
//          conditions, merging them into one syndrome when enabled.
// Assumes: Configuration is static while conditions are pending.
// Notes:   Selection order is lowest slot first; full slots drop input.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Corrected only for resumable wide corrected errors
// - Uncategorized when elected for wide async
// - Implementation syndrome when elected for wide async
// - Implementation content carried into syndrome only for the implementation state
// - Elective legacy states default off
// - Carried severity may raise to uncontainable
// - State uses only processing element condition
// - Pending conditions selected in any order
// - Merging pending conditions is configurable
// - Merged implementation syndrome gives implementation content
// - Other merges record the combined severity
// - Conditions not merged stay pending
// - Narrow state records only four states
// - Corrected outside wide interrupt becomes restartable
module esc_classifier #(
	parameter int SLOTS  = esc_pkg::ESC_SLOTS,
	parameter int IMPL_W = esc_pkg::ESC_IMPL_W
) (
	// Clock, reset, enable
	input  wire  logic              clk_in,
	input  wire  logic              reset_n_in,
	input  wire  logic              ce_in,
	// Static configuration
	input  wire  esc_pkg::esc_cfg_t cfg_in,
	// Incoming error condition
	input  wire  logic              err_valid_in,
	input  wire  esc_pkg::esc_err_t err_in,
	// Exception take request
	input  wire  logic              take_in,
	// Taken exception
	output logic                    exc_valid_out,
	output esc_pkg::esc_syn_t       exc_syn_out,
	output logic [SLOTS-1:0]        exc_mask_out,
	// Pending view
	output logic [SLOTS-1:0]        pending_out,
	output logic                    lost_out
);
	import esc_pkg::*;

	// Per slot storage
	logic [SLOTS-1:0]  valid_reg;
	logic [SLOTS-1:0]  valid_next;
	esc_syn_t          slot_reg  [SLOTS];
	esc_syn_t          slot_next [SLOTS];

	// Output registers
	logic              exc_valid_reg;
	logic              exc_valid_next;
	esc_syn_t          exc_syn_reg;
	esc_syn_t          exc_syn_next;
	logic [SLOTS-1:0]  exc_mask_reg;
	logic [SLOTS-1:0]  exc_mask_next;
	logic              lost_reg;
	logic              lost_next;

	// Classification and selection
	esc_state_t        new_state;
	logic [SLOTS-1:0]  free_pick;
	logic [SLOTS-1:0]  take_pick;
	logic [SLOTS-1:0]  take_mask;
	logic [SLOTS-1:0]  alloc;
	logic              take_go;
	logic              sel_64;
	esc_syn_t          merged;

	// Lowest set bit as a one-hot mask
	function automatic logic [SLOTS-1:0] first_set(
		input logic [SLOTS-1:0] m
	);
		logic [SLOTS-1:0] r;
		logic             seen;
		r = '0;
		seen = 1'b0;
		for (int i = 0; i < SLOTS; i++) begin
			if (m[i] & ~seen) begin
				r[i] = 1'b1;
				seen = 1'b1;
			end
		end
		return r;
	endfunction

	// Classification depends only on the condition and static choices
	esc_classify u_classify (
		.err_in    (err_in),
		.cfg_in    (cfg_in),
		.state_out (new_state)
	);

	// Slot allocation and selection
	always_comb begin
		free_pick = first_set(~valid_reg);
		alloc = err_valid_in ? free_pick : '0;
		lost_next = err_valid_in & ~(|free_pick);
		take_go = take_in & (|valid_reg);
		// Lowest slot first; no relative priority is required
		take_pick = first_set(valid_reg);
		sel_64 = 1'b0;
		for (int i = 0; i < SLOTS; i++) begin
			if (take_pick[i]) begin
				sel_64 = slot_reg[i].to_64;
			end
		end
		take_mask = take_pick;
		if (cfg_in.merge_en) begin
			// Merge only conditions aimed at the same state width
			for (int i = 0; i < SLOTS; i++) begin
				take_mask[i] = valid_reg[i]
					& (slot_reg[i].to_64 == sel_64);
			end
		end
		if (~take_go) begin
			take_mask = '0;
		end
	end

	// Combine the selected conditions into one syndrome
	always_comb begin
		logic       any_impl;
		logic       any_uncat;
		logic [2:0] best_rank;
		logic [2:0] cur_rank;
		esc_state_t best_state;
		logic [IMPL_W-1:0] info;
		any_impl = 1'b0;
		any_uncat = 1'b0;
		best_rank = ESC_RANK_CORR;
		best_state = ESC_ST_CORR;
		info = '0;
		cur_rank = ESC_RANK_CORR;
		for (int i = 0; i < SLOTS; i++) begin
			if (take_mask[i]) begin
				info = info | slot_reg[i].impl_info;
				cur_rank = esc_rank(slot_reg[i].state);
				if (slot_reg[i].state == ESC_ST_IMPL) begin
					any_impl = 1'b1;
				end else if (slot_reg[i].state == ESC_ST_UNCAT) begin
					any_uncat = 1'b1;
				end else if (cur_rank >= best_rank) begin
					best_rank = cur_rank;
					best_state = slot_reg[i].state;
				end
			end
		end
		merged = ESC_SYN_RESET;
		merged.to_64 = sel_64;
		merged.impl_info = info;
		if (sel_64 & any_impl) begin
			merged.state = ESC_ST_IMPL;
		end else if (sel_64 & any_uncat) begin
			// Unknown content outranks every graded state
			merged.state = ESC_ST_UNCAT;
		end else begin
			merged.state = best_state;
		end
		if (merged.state != ESC_ST_IMPL) begin
			// Extra content only travels with the implementation state
			merged.impl_info = '0;
		end
	end

	// Next state of slots and outputs
	always_comb begin
		// Freed slots are not reused in the same cycle, so set never
		// collides with clear
		valid_next = (valid_reg & ~take_mask) | alloc;
		for (int i = 0; i < SLOTS; i++) begin
			slot_next[i] = slot_reg[i];
			if (alloc[i]) begin
				slot_next[i].state = new_state;
				slot_next[i].to_64 = err_in.to_64;
				// Only the element's own view is kept
				slot_next[i].impl_info = err_in.impl_info;
			end
		end
		exc_valid_next = take_go;
		exc_mask_next = take_mask;
		exc_syn_next = take_go ? merged : exc_syn_reg;
	end

	// Registers
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			valid_reg <= '0;
			for (int i = 0; i < SLOTS; i++) begin
				slot_reg[i] <= ESC_SYN_RESET;
			end
			exc_valid_reg <= 1'b0;
			exc_syn_reg <= ESC_SYN_RESET;
			exc_mask_reg <= '0;
			lost_reg <= 1'b0;
		end else if (ce_in) begin
			valid_reg <= valid_next;
			for (int i = 0; i < SLOTS; i++) begin
				slot_reg[i] <= slot_next[i];
			end
			exc_valid_reg <= exc_valid_next;
			exc_syn_reg <= exc_syn_next;
			exc_mask_reg <= exc_mask_next;
			lost_reg <= lost_next;
		end
	end

	assign exc_valid_out = exc_valid_reg;
	assign exc_syn_out = exc_syn_reg;
	assign exc_mask_out = exc_mask_reg;
	assign pending_out = valid_reg;
	assign lost_out = lost_reg;

endmodule

`default_nettype wire

/* verilog/esc_classify.sv */
// Purpose: Classify one error condition into a recorded error state.
// Assumes: Purely combinational; caller registers the result.
// Notes:   Depends only on the condition and static configuration.
`timescale 1ns/1ps
`default_nettype none

module esc_classify (
	// Condition and configuration
	input  wire esc_pkg::esc_err_t err_in,
	input  wire esc_pkg::esc_cfg_t cfg_in,
	// Result
	output var  esc_pkg::esc_state_t state_out
);
	import esc_pkg::*;

	logic wide_async;
	logic sev_uc;

	always_comb begin
		wide_async = err_in.async_exc & err_in.to_64;
		// Optional use of carried severity; absent severity is ignored
		sev_uc = cfg_in.use_severity & err_in.sev_valid
			& err_in.sev_uncont;
		state_out = ESC_ST_RESTART;
		if (wide_async & cfg_in.elect_uncat) begin
			state_out = ESC_ST_UNCAT;
		end else if (wide_async & cfg_in.elect_impl) begin
			state_out = ESC_ST_IMPL;
		end else if (err_in.silent | sev_uc
			| (~err_in.resumable & ~err_in.synced)) begin
			state_out = ESC_ST_UNCONT;
		end else if (~err_in.resumable) begin
			state_out = ESC_ST_UNREC;
		end else if (err_in.needs_repair) begin
			state_out = ESC_ST_RECOV;
		end else if (err_in.corrected & err_in.to_64) begin
			state_out = ESC_ST_CORR;
		end else begin
			// Narrow state never sees corrected or elective states
			state_out = ESC_ST_RESTART;
		end
	end

endmodule

`default_nettype wire

/* verilog/esc_pkg.sv */
// Purpose: Shared types and constants for the error state classifier.
// Assumes: One core clock; all pending conditions are system error
//          interrupt conditions aimed at this processing element.
// Notes:   State codes are the values placed in the syndrome state field.
package esc_pkg;

	// Default sizes
	localparam int ESC_SLOTS  = 4;
	localparam int ESC_IMPL_W = 16;

	// Recorded processing element error states
	typedef enum logic [2:0] {
		ESC_ST_UNCAT   = 3'h0,
		ESC_ST_IMPL    = 3'h1,
		ESC_ST_UNCONT  = 3'h2,
		ESC_ST_UNREC   = 3'h3,
		ESC_ST_RECOV   = 3'h4,
		ESC_ST_RESTART = 3'h5,
		ESC_ST_CORR    = 3'h6
	} esc_state_t;

	// Severity ranks used when conditions are merged
	localparam logic [2:0] ESC_RANK_CORR    = 3'h0;
	localparam logic [2:0] ESC_RANK_RESTART = 3'h1;
	localparam logic [2:0] ESC_RANK_RECOV   = 3'h2;
	localparam logic [2:0] ESC_RANK_UNREC   = 3'h3;
	localparam logic [2:0] ESC_RANK_UNCONT  = 3'h4;

	// One incoming error condition, as seen by this processing element
	typedef struct packed {
		logic                  silent;       // Silently propagated
		logic                  corrected;    // Error was corrected
		logic                  resumable;    // Resume at return address
		logic                  needs_repair; // Must locate and repair
		logic                  synced;       // Synchronized by sync events
		logic                  async_exc;    // Taken asynchronously
		logic                  to_64;        // Taken to the 64-bit state
		logic                  sev_valid;    // Response carries severity
		logic                  sev_uncont;   // Severity says uncontainable
		logic [ESC_IMPL_W-1:0] impl_info;    // Implementation syndrome
	} esc_err_t;

	// Static elective reporting choices
	typedef struct packed {
		logic elect_uncat;
		logic elect_impl;
		logic use_severity;
		logic merge_en;
	} esc_cfg_t;

	// Syndrome of one taken exception
	typedef struct packed {
		esc_state_t            state;
		logic                  to_64;
		logic [ESC_IMPL_W-1:0] impl_info;
	} esc_syn_t;

	localparam esc_syn_t ESC_SYN_RESET = '0;

	// Severity rank of a plain state; elective states are handled apart
	function automatic logic [2:0] esc_rank(input esc_state_t st);
		logic [2:0] r;
		r = ESC_RANK_UNCONT;
		unique case (st)
			ESC_ST_CORR:    r = ESC_RANK_CORR;
			ESC_ST_RESTART: r = ESC_RANK_RESTART;
			ESC_ST_RECOV:   r = ESC_RANK_RECOV;
			ESC_ST_UNREC:   r = ESC_RANK_UNREC;
			default:        r = ESC_RANK_UNCONT;
		endcase
		return r;
	endfunction

endpackage
